/* irap_top.sv */
`include "irap_consts.svh"
module irap_top
    import irap_pkg::*;
#(
    parameter int AW = `IRAP_ADDR_W,
    parameter int DW = `IRAP_DATA_W,
    parameter int DEPTH = `IRAP_FIFO_DEPTH,
    parameter logic [AW-1:0] DEV_ADDR = `IRAP_ADDR_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic undervoltage_lockout_enable_pin,
    input wire logic config_done,
    input wire logic bias_supply_undervoltage,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [DW-1:0] wr_addr,
    output logic [DW-1:0] wr_data,
    output logic [DW-1:0] rd_addr,
    input wire logic [DW-1:0] rd_data
);
    irap_state_t state_q;
    irap_wr_if #(.W(2*DW)) wq_if();
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic scl_r;
    logic sda_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic en_s1_q;
    logic en_s2_q;
    logic link_en;
    logic [DW-1:0] shift_q;
    logic [2:0] bit_q;
    logic [DW-1:0] ptr_q;
    logic ptr_loaded_q;
    logic read_q;
    logic ack_ok_q;
    logic drive_low_q;
    logic [DW-1:0] tx_q;
    logic [DW-1:0] fifo_a;
    logic rise_seen_q;

    // Pins pass two flops; the third stage only feeds edge detection.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
        end
    end
    assign scl_r = scl_s_q[1];
    assign sda_r = sda_s_q[1];
    assign scl_rise = scl_s_q[1] && !scl_s_q[2];
    assign scl_fall = !scl_s_q[1] && scl_s_q[2];
    assign start_det = scl_r && scl_s_q[2] && !sda_r && sda_s_q[2];
    assign stop_det = scl_r && scl_s_q[2] && sda_r && !sda_s_q[2];

    // The combined enable is a level from outside, so it is synchronised.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
        end else begin
            en_s1_q <= undervoltage_lockout_enable_pin && config_done
                       && !bias_supply_undervoltage;
            en_s2_q <= en_s1_q;
        end
    end
    assign link_en = en_s2_q;

    // The clock fall that closes a start condition carries no bit, so a bit only
    // counts when its own rising edge has been seen since the last fall.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || start_det) begin
            rise_seen_q <= 1'b0;
        end else if (scl_rise) begin
            rise_seen_q <= 1'b1;
        end else if (scl_fall) begin
            rise_seen_q <= 1'b0;
        end
    end

    // Main bus state machine; the clock edges of the controller and start and stop conditions advance it.
    // Clock only sampled.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !link_en) begin
            state_q <= IRAP_IDLE;
            bit_q <= `IRAP_BIT_FIRST;
            shift_q <= `IRAP_BYTE_ZERO;
            read_q <= 1'b0;
            ptr_loaded_q <= 1'b0;
            ack_ok_q <= 1'b0;
        end else if (start_det) begin
            state_q <= IRAP_ADDR;
            bit_q <= `IRAP_BIT_FIRST;
            ptr_loaded_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= IRAP_IDLE;
        end else begin
            case (state_q)
                IRAP_IDLE: begin
                    state_q <= IRAP_IDLE;
                end
                IRAP_ADDR, IRAP_RXB: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[DW-2:0], sda_r};
                    end
                    if (scl_fall && rise_seen_q) begin
                        if (bit_q == `IRAP_BIT_LAST) begin
                            bit_q <= `IRAP_BIT_FIRST;
                            if (state_q == IRAP_ADDR) begin
                                if (shift_q[DW-1:1] == DEV_ADDR) begin
                                    state_q <= IRAP_AACK;
                                    read_q <= shift_q[0];
                                end else begin
                                    state_q <= IRAP_IDLE;
                                end
                            end else begin
                                ack_ok_q <= ptr_loaded_q ? wq_if.ready : 1'b1;
                                state_q <= IRAP_RACK;
                            end
                        end else begin
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                end
                IRAP_AACK: begin
                    if (scl_fall) begin
                        state_q <= read_q ? IRAP_TXB : IRAP_RXB;
                    end
                end
                IRAP_RACK: begin
                    if (scl_fall) begin
                        state_q <= ack_ok_q ? IRAP_RXB : IRAP_IDLE;
                        ptr_loaded_q <= 1'b1;
                    end
                end
                IRAP_TXB: begin
                    if (scl_fall) begin
                        if (bit_q == `IRAP_BIT_LAST) begin
                            bit_q <= `IRAP_BIT_FIRST;
                            state_q <= IRAP_TACK;
                        end else begin
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                end
                IRAP_TACK: begin
                    if (scl_rise) begin
                        ack_ok_q <= !sda_r;
                    end
                    if (scl_fall) begin
                        state_q <= ack_ok_q ? IRAP_TXB : IRAP_IDLE;
                    end
                end
                default: begin
                    state_q <= IRAP_IDLE;
                end
            endcase
        end
    end

    // Register pointer handling.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ptr_q <= `IRAP_BYTE_ZERO;
        end else if (link_en && !start_det && !stop_det && scl_fall) begin
            if (state_q == IRAP_RACK && !ptr_loaded_q) begin
                ptr_q <= shift_q;
            end else if (state_q == IRAP_RACK && ack_ok_q) begin
                ptr_q <= ptr_q + `IRAP_PTR_STEP;
            end else if (state_q == IRAP_TACK && ack_ok_q) begin
                ptr_q <= ptr_q + `IRAP_PTR_STEP;
            end
        end
    end
    assign rd_addr = ptr_q;

    // Write bytes enter the FIFO at the clock fall that ends their acknowledge bit.
    // Store at pointer.
    assign wq_if.valid = link_en && state_q == IRAP_RACK && ptr_loaded_q
                         && ack_ok_q && scl_fall && !start_det && !stop_det;
    assign wq_if.data = {ptr_q, shift_q};

    irap_fifo #(.W(2*DW), .DEPTH(DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_if(wq_if),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data({fifo_a, wr_data})
    );
    assign wr_addr = fifo_a;

    // Transmit shifter follows the register contents while the clock is low in the first bit.
    // Loading only after the pointer step keeps a sequential read from sending
    // the previous register's lower bits.
    // Pointed register returned.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_q <= `IRAP_BYTE_ZERO;
        end else if (scl_fall && state_q == IRAP_TXB) begin
            tx_q <= {tx_q[DW-2:0], 1'b0};
        end else if (state_q == IRAP_TXB && bit_q == `IRAP_BIT_FIRST && !scl_r) begin
            tx_q <= rd_data;
        end
    end

    // The low is driven from a flop so that it changes only after the clock falls.
    // Acknowledge bytes.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !link_en) begin
            drive_low_q <= 1'b0;
        end else if (scl_fall || start_det || stop_det) begin
            drive_low_q <= 1'b0;
        end else if (state_q == IRAP_AACK && !scl_r) begin
            drive_low_q <= 1'b1;
        end else if (state_q == IRAP_RACK && !scl_r) begin
            drive_low_q <= ack_ok_q;
        end else if (state_q == IRAP_TXB && !scl_r && bit_q == `IRAP_BIT_FIRST) begin
            drive_low_q <= !rd_data[DW-1];
        end else if (state_q == IRAP_TXB && !scl_r) begin
            drive_low_q <= !tx_q[DW-1];
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe = drive_low_q;
endmodule

/* irap_consts.svh */
`ifndef IRAP_CONSTS_SVH
`define IRAP_CONSTS_SVH
`define IRAP_ADDR_W 7
`define IRAP_DATA_W 8
`define IRAP_FIFO_DEPTH 4
`define IRAP_ADDR_DEFAULT 7'h40
`define IRAP_BIT_LAST 3'h7
`define IRAP_BIT_FIRST 3'h0
`define IRAP_PTR_STEP 8'h01
`define IRAP_BYTE_ZERO 8'h00
`endif

/* irap_pkg.sv */
package irap_pkg;
    typedef enum logic [6:0] {
        IRAP_IDLE = 7'b000_0001,
        IRAP_ADDR = 7'b000_0010,
        IRAP_AACK = 7'b000_0100,
        IRAP_RXB  = 7'b000_1000,
        IRAP_RACK = 7'b001_0000,
        IRAP_TXB  = 7'b010_0000,
        IRAP_TACK = 7'b100_0000
    } irap_state_t;
endpackage

/* irap_wr_if.sv */
interface irap_wr_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

/* irap_fifo.sv */
module irap_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    irap_wr_if.snk in_if,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_if.ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_if.data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* irap_top_props.sv */
module irap_top_props #(
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic undervoltage_lockout_enable_pin,
    input wire logic config_done,
    input wire logic bias_supply_undervoltage,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [DW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [DW-1:0] rd_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // The enable inputs pass a two-flop chain, so six idle cycles leave slack for it.
    chk_sda_opendrain: assert property (sda_o == 1'b0)
        else $error("sda_o not low");
    chk_pin_quiet: assert property ((!undervoltage_lockout_enable_pin)[*6] |-> !sda_oe)
        else $error("sda_oe while enable pin low");
    chk_cfg_quiet: assert property ((!config_done)[*6] |-> !sda_oe)
        else $error("sda_oe before configuration");
    chk_uv_quiet: assert property (bias_supply_undervoltage[*6] |-> !sda_oe)
        else $error("sda_oe during undervoltage");
    chk_oe_hold_high: assert property ($rose(scl_i) |=> $stable(sda_oe)[*3])
        else $error("sda_oe moved while scl high");
    chk_fifo_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
        else $error("write entry lost while stalled");
    chk_reset_state: assert property ($rose(rst_n) |-> !sda_oe && !wr_valid && rd_addr == 8'h00)
        else $error("bad state after reset");
    chk_ptr_step: assert property ($rose(wr_valid) |-> ##[0:2] rd_addr == wr_addr + 8'h01)
        else $error("pointer did not step after write");
    chk_push_enabled: assert property ($rose(wr_valid) |->
        undervoltage_lockout_enable_pin && config_done && !bias_supply_undervoltage)
        else $error("write accepted while disabled");
endmodule

bind irap_top irap_top_props #(.DW(DW)) props_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .undervoltage_lockout_enable_pin(undervoltage_lockout_enable_pin),
    .config_done(config_done), .bias_supply_undervoltage(bias_supply_undervoltage),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr));

/* irap_ctrl_model.sv */
module irap_ctrl_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic s);
        #12 sda_low = !b;
        #12 scl = 1'b1;
        #12 s = sda_line;
        #12 scl = 1'b0;
    endtask
    task automatic start();
        #12 sda_low = 1'b0;
        #12 scl = 1'b1;
        #24 sda_low = 1'b1;
        #24 scl = 1'b0;
    endtask
    task automatic stop();
        #12 sda_low = 1'b1;
        #12 scl = 1'b1;
        #24 sda_low = 1'b0;
        #24;
    endtask
    // The ninth bit drives ack_in; a low line seen there means acknowledged.
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask
endmodule

/* test_i2c_register_access_port.sv */
module test_i2c_register_access_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h2d;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_pin = 1'b1;
    logic cfg = 1'b1;
    logic uv = 1'b0;
    logic wr_ready = 1'b0;
    logic scl, m_low, sda_oe, sda_o, wr_valid, ack;
    logic [7:0] wr_addr, wr_data, rd_addr, rx, ptr;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int n_compared = 0;
    int seed = 72;
    // Pull-up wins unless someone pulls low.
    wire sda_line = ((sda_oe && !sda_o) || m_low) ? 1'b0 : 1'b1;
    wire [7:0] rd_data = reg_val(rd_addr);
    always #2.5 ref_clk = !ref_clk;
    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction
    irap_top #(.DEV_ADDR(DEV)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .undervoltage_lockout_enable_pin(en_pin), .config_done(cfg),
        .bias_supply_undervoltage(uv), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
    irap_ctrl_model ctrl_u (.scl(scl), .sda_low(m_low), .sda_line(sda_line));
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic addr_phase(input logic [7:0] p);
        ctrl_u.start();
        ctrl_u.xfer({DEV, 1'b0}, 1'b1, rx, ack);
        check("addr ack", 1'b0, ack);
        ctrl_u.xfer(p, 1'b1, rx, ack);
        check("pointer ack", 1'b0, ack);
    endtask
    // Bytes past the free room must be refused, since the bus cannot be stretched.
    task automatic write_burst(input logic [7:0] p, input int n, input int room);
        logic [7:0] d;
        addr_phase(p);
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            ctrl_u.xfer(d, 1'b1, rx, ack);
            if (i < room) begin
                check("data ack", 1'b0, ack);
                exp_q.push_back({p + i[7:0], d});
            end else begin
                check("full refusal", 1'b1, ack);
            end
        end
        ctrl_u.stop();
        check("pointer after write", {p + 8'(room)}, rd_addr);
    endtask
    task automatic read_burst(input logic [7:0] p, input int n);
        addr_phase(p);
        ctrl_u.start();
        ctrl_u.xfer({DEV, 1'b1}, 1'b1, rx, ack);
        check("read addr ack", 1'b0, ack);
        for (int i = 0; i < n; i++) begin
            ctrl_u.xfer(8'hff, i == n - 1, rx, ack);
            check("read data", reg_val(p + i[7:0]), rx);
        end
        ctrl_u.stop();
    endtask
    task automatic drain();
        @(negedge ref_clk) wr_ready = 1'b1;
        while (exp_q.size() > 0) begin
            check("write entry", {1'b1, exp_q.pop_front()}, {wr_valid, wr_addr, wr_data});
            @(negedge ref_clk);
        end
        wr_ready = 1'b0;
        check("fifo empty", 1'b0, wr_valid);
    endtask
    task automatic gate(input int k);
        logic [7:0] p;
        p = rd_addr;
        @(negedge ref_clk);
        en_pin = (k != 0);
        cfg = (k != 1);
        uv = (k == 2);
        ctrl_u.start();
        ctrl_u.xfer({DEV, 1'b0}, 1'b1, rx, ack);
        check("gated ack", 1'b1, ack);
        ctrl_u.stop();
        @(negedge ref_clk);
        en_pin = 1'b1;
        cfg = 1'b1;
        uv = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("kept pointer", p, rd_addr);
        ctrl_u.start();
        ctrl_u.xfer({DEV, 1'b0}, 1'b1, rx, ack);
        check("resumed ack", 1'b0, ack);
        ctrl_u.stop();
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        write_burst(8'hff, 2, 2);
        $display("test wrapping write done");
        ctrl_u.start();
        ctrl_u.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, rx, ack);
        check("foreign addr", 1'b1, ack);
        ctrl_u.xfer(8'h00, 1'b1, rx, ack);
        check("ignored byte", 1'b1, ack);
        ctrl_u.stop();
        $display("test foreign address done");
        ptr = $random(seed);
        read_burst(ptr, 3);
        $display("test sequential read done");
        ptr = $random(seed);
        write_burst(ptr, 4, 2);
        drain();
        $display("test full buffer done");
        for (int k = 0; k < 3; k++) gate(k);
        $display("test gating done");
        print_verdict();
    end
endmodule
